// ===== rtl/cbrres_decode.sv
`timescale 1ns/1ps
`default_nettype none
`include "cbrres_defines.svh"

// Opcode to condition decode and condition evaluation, purely combinational
module cbrres_decode
  import cbrres_pkg::*;
(
  input  wire logic [7:0]           opcode_i,
  input  wire logic [7:0]           opcode2_i,
  input  wire logic                 carry_flag_i,
  input  wire logic                 zero_flag_i,
  input  wire logic [15:0]          count_register_low_i,
  output cbrres_pkg::cbrres_cond_t  cond_o,
  output logic                      near_o,
  output logic                      taken_o
);
  // Decode one byte of the short table; near opcodes go through near_cond
  function automatic cbrres_cond_t short_cond(input logic [7:0] op);
    if (op == `CBRRES_OP_ABOVE) short_cond = CBRRES_C_ABOVE;
    else if (op == `CBRRES_OP_AE) short_cond = CBRRES_C_AE;
    else if (op == `CBRRES_OP_BELOW) short_cond = CBRRES_C_BELOW;
    else if (op == `CBRRES_OP_BE) short_cond = CBRRES_C_BE;
    else if (op == `CBRRES_OP_EQUAL) short_cond = CBRRES_C_EQUAL;
    else if (op == `CBRRES_OP_CXZ) short_cond = CBRRES_C_CXZ;
    else short_cond = CBRRES_C_NONE;
  endfunction

  function automatic cbrres_cond_t near_cond(input logic [7:0] op);
    if (op == `CBRRES_OP_N_ABOVE) near_cond = CBRRES_C_ABOVE;
    else if (op == `CBRRES_OP_N_AE) near_cond = CBRRES_C_AE;
    else if (op == `CBRRES_OP_N_BELOW) near_cond = CBRRES_C_BELOW;
    else if (op == `CBRRES_OP_N_BE) near_cond = CBRRES_C_BE;
    else if (op == `CBRRES_OP_N_EQUAL) near_cond = CBRRES_C_EQUAL;
    else near_cond = CBRRES_C_NONE;
  endfunction

  // Condition from opcode and flags
  always_comb
  begin
    near_o = (opcode_i == `CBRRES_OP_TWO_BYTE);
    cond_o = near_o ? near_cond(opcode2_i) : short_cond(opcode_i);
    case (cond_o)
      CBRRES_C_ABOVE: taken_o = !carry_flag_i && !zero_flag_i;
      CBRRES_C_AE:    taken_o = !carry_flag_i;
      CBRRES_C_BELOW: taken_o = carry_flag_i;
      CBRRES_C_BE:    taken_o = carry_flag_i || zero_flag_i;
      CBRRES_C_EQUAL: taken_o = zero_flag_i;
      CBRRES_C_CXZ:   taken_o = (count_register_low_i == 16'h0000);
      default:        taken_o = 1'b0;
    endcase
  end
endmodule // cbrres_decode

`default_nettype wire

// ===== rtl/cbrres_defines.svh
`ifndef CBRRES_DEFINES_SVH
`define CBRRES_DEFINES_SVH

// Wishbone register byte offsets
`define CBRRES_OFF_CTRL      8'h00
`define CBRRES_OFF_STATUS    8'h04
`define CBRRES_OFF_IRQ_STAT  8'h08
`define CBRRES_OFF_IRQ_MASK  8'h0c
`define CBRRES_OFF_LIMIT     8'h10
`define CBRRES_OFF_COUNT     8'h14

// Control register fields
`define CBRRES_CTRL_PROT_BIT 0
`define CBRRES_CTRL_V86_BIT  1
`define CBRRES_CTRL_RESET    2'h0

// Interrupt status bits
`define CBRRES_IRQ_TAKEN     0
`define CBRRES_IRQ_NOTTAKEN  1
`define CBRRES_IRQ_FAULT     2
`define CBRRES_IRQ_W         3

// Opcodes
`define CBRRES_OP_TWO_BYTE   8'h0f
`define CBRRES_OP_ABOVE      8'h77
`define CBRRES_OP_AE         8'h73
`define CBRRES_OP_BELOW      8'h72
`define CBRRES_OP_BE         8'h76
`define CBRRES_OP_EQUAL      8'h74
`define CBRRES_OP_CXZ        8'he3
`define CBRRES_OP_N_ABOVE    8'h87
`define CBRRES_OP_N_AE       8'h83
`define CBRRES_OP_N_BELOW    8'h82
`define CBRRES_OP_N_BE       8'h86
`define CBRRES_OP_N_EQUAL    8'h84

// Execution clocks, fault vector, 16-bit pointer mask and limit reset value
`define CBRRES_CLK_FLAG_TAKEN  4'h3
`define CBRRES_CLK_FLAG_NOT    4'h1
`define CBRRES_CLK_CXZ_TAKEN   4'h8
`define CBRRES_CLK_CXZ_NOT     4'h5
`define CBRRES_GP_VECTOR       8'h0d
`define CBRRES_IP16_MASK       32'h0000ffff
`define CBRRES_LIMIT_RESET     32'hffffffff

`endif

// ===== rtl/cbrres_pkg.sv
package cbrres_pkg;
  typedef enum logic [2:0] {
    CBRRES_C_NONE  = 3'h0,
    CBRRES_C_ABOVE = 3'h1,
    CBRRES_C_AE    = 3'h2,
    CBRRES_C_BELOW = 3'h3,
    CBRRES_C_BE    = 3'h4,
    CBRRES_C_EQUAL = 3'h5,
    CBRRES_C_CXZ   = 3'h6
  } cbrres_cond_t;

  typedef enum logic [1:0] {
    CBRRES_IDLE = 2'b00,
    CBRRES_BUSY = 2'b01,
    CBRRES_DONE = 2'b11
  } cbrres_state_t;
endpackage

// ===== rtl/cbrres_top.sv
// What this block does
// - Above branch, short or near, taken only when carry and zero both clear.
// - Above-or-equal branch, short or near, taken only when carry clear.
// - Below branch, short or near, taken only when carry set.
// - Below-or-equal branch taken when carry or zero set.
// - Short carry branch shares the below encoding, taken when carry set.
// - Equal branch, short or near, taken only when zero set.
// - Count-zero short branch taken when 16-bit count is zero, flags ignored.
// - Taken branch adds sign-extended 8, 16 or 32-bit displacement to pointer.
// - With 16-bit operand width the new pointer keeps only its low half.
// - Flag branches finish in 3 clocks taken, 1 clock not taken.
// - Count-zero branch finishes in 8 clocks taken, 5 not taken.
// - Protected mode taken target beyond segment limit raises fault 13.
//
// Register access over Wishbone and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "cbrres_defines.svh"

module cbrres_top
  import cbrres_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Instruction issue from the front end
  input  wire logic        issue_valid_i,
  output logic             issue_ready_o,
  input  wire logic [7:0]  opcode_i,
  input  wire logic [7:0]  opcode2_i,
  input  wire logic [31:0] displacement_i,
  input  wire logic [1:0]  disp_size_i,
  input  wire logic        operand_width_attribute_i,
  input  wire logic [31:0] instruction_pointer_i,
  input  wire logic        carry_flag_i,
  input  wire logic        zero_flag_i,
  // Result to the front end and fault logic
  output logic             done_o,
  output logic             branch_taken_o,
  output logic [31:0]      instruction_pointer_o,
  output logic             fault_o,
  output logic [7:0]       fault_vector_o,
  output logic             invalid_o,
  // Classic Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  output logic             irq_o
);
  import cbrres_pkg::*;

  // All state in one struct
  typedef struct packed {
    cbrres_state_t            state;
    logic [3:0]               cnt;
    logic                     taken;
    logic                     flt;
    logic [31:0]              target;
    logic                     ready;
    logic                     done;
    logic                     btaken;
    logic [31:0]              ip_out;
    logic                     fault;
    logic [7:0]               vec;
    logic                     invalid;
    logic [1:0]               ctrl;
    logic [31:0]              limit;
    logic [15:0]              count;
    logic [`CBRRES_IRQ_W-1:0] istat;
    logic [`CBRRES_IRQ_W-1:0] imask;
    logic [31:0]              rdata;
    logic                     ack;
    logic                     irq;
  } cbrres_state_s_t;

  cbrres_state_s_t s_q;
  cbrres_state_s_t s_d;

  cbrres_cond_t cond;
  logic         near;
  logic         cond_true;

  cbrres_decode u_decode (
    .opcode_i             (opcode_i),
    .opcode2_i            (opcode2_i),
    .carry_flag_i         (carry_flag_i),
    .zero_flag_i          (zero_flag_i),
    .count_register_low_i (s_q.count),
    .cond_o               (cond),
    .near_o               (near),
    .taken_o              (cond_true)
  );

  // Sign-extend the displacement by its size code: 0 byte, 1 word, else dword
  function automatic logic [31:0] sext(input logic [31:0] d, input logic [1:0] sz);
    if (sz == 2'h0) sext = {{24{d[7]}}, d[7:0]};
    else if (sz == 2'h1) sext = {{16{d[15]}}, d[15:0]};
    else sext = d;
  endfunction

  // Merge a write into a register by byte enables
  function automatic logic [31:0] bmerge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] sel);
    for (int i = 0; i < 4; i++)
      bmerge[i*8 +: 8] = sel[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
  endfunction

  logic [31:0] sum;
  logic [31:0] tgt;
  logic        prot;
  logic        wb_req;
  logic        wb_wr;
  logic [31:0] cnt_m;
  logic [`CBRRES_IRQ_W-1:0] ev;

  // Target and limit test; fault only in protected mode, never in V86
  always_comb
  begin
    sum  = instruction_pointer_i + sext(displacement_i, disp_size_i);
    tgt  = operand_width_attribute_i ? sum : (sum & `CBRRES_IP16_MASK);
    prot = s_q.ctrl[`CBRRES_CTRL_PROT_BIT] && !s_q.ctrl[`CBRRES_CTRL_V86_BIT];
    wb_req = wb_cyc_i && wb_stb_i && !s_q.ack;
    // A write lands on the edge where the master sees ack, never a cycle earlier
    wb_wr  = wb_cyc_i && wb_stb_i && wb_we_i && s_q.ack;
    cnt_m  = bmerge({16'h0, s_q.count}, wb_dat_i, wb_sel_i);
  end

  // Next state
  always_comb
  begin
    s_d = s_q;
    s_d.done = 1'b0;
    s_d.ack = 1'b0;
    ev = '0;

    // Branch sequencer; flags are inputs only and never driven back
    case (s_q.state)
      CBRRES_IDLE:
      begin
        if (issue_valid_i && s_q.ready)
        begin
          s_d.ready = 1'b0;
          s_d.taken = cond_true;
          s_d.target = tgt;
          s_d.flt = cond_true && prot && (tgt > s_q.limit);
          if (cond == CBRRES_C_CXZ)
            s_d.cnt = cond_true ? `CBRRES_CLK_CXZ_TAKEN : `CBRRES_CLK_CXZ_NOT;
          else
            s_d.cnt = cond_true ? `CBRRES_CLK_FLAG_TAKEN : `CBRRES_CLK_FLAG_NOT;
          s_d.invalid = (cond == CBRRES_C_NONE);
          if (cond == CBRRES_C_NONE)
            s_d.cnt = 4'h1;
          s_d.state = CBRRES_BUSY;
        end
      end
      CBRRES_BUSY:
      begin
        // Count includes the issue cycle, so done lands cnt clocks after issue
        if (s_q.cnt <= 4'h2)
        begin
          s_d.done = 1'b1;
          s_d.btaken = s_q.taken && !s_q.flt && !s_q.invalid;
          s_d.ip_out = (s_q.taken && !s_q.flt) ? s_q.target : s_q.ip_out;
          s_d.fault = s_q.flt;
          s_d.vec = s_q.flt ? `CBRRES_GP_VECTOR : 8'h00;
          ev[`CBRRES_IRQ_TAKEN] = s_q.taken && !s_q.flt;
          ev[`CBRRES_IRQ_NOTTAKEN] = !s_q.taken && !s_q.invalid;
          ev[`CBRRES_IRQ_FAULT] = s_q.flt;
          s_d.state = CBRRES_DONE;
        end
        else
          s_d.cnt = s_q.cnt - 4'h1;
      end
      CBRRES_DONE:
      begin
        s_d.ready = 1'b1;
        s_d.state = CBRRES_IDLE;
      end
      default:
        s_d.state = CBRRES_IDLE;
    endcase

    // One-clock instructions complete at the issue edge itself
    if (s_q.state == CBRRES_IDLE && issue_valid_i && s_q.ready && s_d.cnt == 4'h1)
    begin
      s_d.done = 1'b1;
      s_d.btaken = 1'b0;
      s_d.fault = 1'b0;
      s_d.vec = 8'h00;
      ev[`CBRRES_IRQ_NOTTAKEN] = !s_d.invalid;
      s_d.ready = 1'b1;
      s_d.state = CBRRES_IDLE;
    end

    // Wishbone slave, one-cycle registered ack with read data latched beside it
    if (wb_req)
    begin
      s_d.ack = 1'b1;
      s_d.rdata = 32'h0000_0000;
      if (wb_adr_i == `CBRRES_OFF_CTRL)
        s_d.rdata = {30'h0, s_q.ctrl};
      else if (wb_adr_i == `CBRRES_OFF_STATUS)
        s_d.rdata = {28'h0, s_q.state == CBRRES_IDLE, s_q.fault, s_q.btaken, s_q.invalid};
      else if (wb_adr_i == `CBRRES_OFF_IRQ_STAT)
        s_d.rdata = {29'h0, s_q.istat};
      else if (wb_adr_i == `CBRRES_OFF_IRQ_MASK)
        s_d.rdata = {29'h0, s_q.imask};
      else if (wb_adr_i == `CBRRES_OFF_LIMIT)
        s_d.rdata = s_q.limit;
      else if (wb_adr_i == `CBRRES_OFF_COUNT)
        s_d.rdata = {16'h0, s_q.count};
    end

    // Register writes, committed in the ack cycle while the request still stands
    if (wb_wr)
    begin
      if (wb_adr_i == `CBRRES_OFF_CTRL)
      begin
        if (wb_sel_i[0])
          s_d.ctrl = wb_dat_i[1:0];
      end
      else if (wb_adr_i == `CBRRES_OFF_IRQ_STAT)
      begin
        if (wb_sel_i[0])
          s_d.istat = s_q.istat & ~wb_dat_i[`CBRRES_IRQ_W-1:0];
      end
      else if (wb_adr_i == `CBRRES_OFF_IRQ_MASK)
      begin
        if (wb_sel_i[0])
          s_d.imask = wb_dat_i[`CBRRES_IRQ_W-1:0];
      end
      else if (wb_adr_i == `CBRRES_OFF_LIMIT)
        s_d.limit = bmerge(s_q.limit, wb_dat_i, wb_sel_i);
      else if (wb_adr_i == `CBRRES_OFF_COUNT)
        s_d.count = cnt_m[15:0];
    end

    // Event set wins over a same-cycle clear
    s_d.istat = s_d.istat | ev;
    s_d.irq = |(s_d.istat & s_d.imask);
  end

  // State register with synchronous reset
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s_q <= '0;
      s_q.state <= CBRRES_IDLE;
      s_q.ready <= 1'b1;
      s_q.ctrl <= `CBRRES_CTRL_RESET;
      s_q.limit <= `CBRRES_LIMIT_RESET;
    end
    else
      s_q <= s_d;
  end

  // Outputs straight from the state register
  assign issue_ready_o = s_q.ready;
  assign done_o = s_q.done;
  assign branch_taken_o = s_q.btaken;
  assign instruction_pointer_o = s_q.ip_out;
  assign fault_o = s_q.fault;
  assign fault_vector_o = s_q.vec;
  assign invalid_o = s_q.invalid;
  assign wb_dat_o = s_q.rdata;
  assign wb_ack_o = s_q.ack;
  assign irq_o = s_q.irq;
endmodule // cbrres_top

`default_nettype wire

// ===== testbench/cbrres_chk.sv
`timescale 1ns/1ps
`default_nettype none
module cbrres_chk (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        issue_valid_i,
  input wire logic        issue_ready_o,
  input wire logic [7:0]  opcode_i,
  input wire logic        operand_width_attribute_i,
  input wire logic        done_o,
  input wire logic        branch_taken_o,
  input wire logic [31:0] instruction_pointer_o,
  input wire logic        fault_o,
  input wire logic [7:0]  fault_vector_o,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o
);
  logic [3:0] cnt_q;
  logic       cxz_q;
  logic       w16_q;

  // Edges since acceptance; a back-to-back accept restarts the count
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cnt_q <= 4'h0;
    else if (issue_valid_i && issue_ready_o)
    begin
      cnt_q <= 4'h1;
      cxz_q <= (opcode_i == 8'he3);
      w16_q <= !operand_width_attribute_i;
    end
    else if (done_o)
      cnt_q <= 4'h0;
    else if (cnt_q != 4'h0)
      cnt_q <= cnt_q + 4'h1;
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Faulted branches, flag or count-zero, report not taken, so both latency checks leave them out
  AST_FLAG_LAT: assert property (done_o && !fault_o && !cxz_q |->
    cnt_q == (branch_taken_o ? 4'h3 : 4'h1)) else $error("flag branch latency");
  AST_CXZ_LAT: assert property (done_o && !fault_o && cxz_q |->
    cnt_q == (branch_taken_o ? 4'h8 : 4'h5)) else $error("count branch latency");
  AST_BUSY: assert property (cnt_q != 4'h0 && !done_o |-> !issue_ready_o)
    else $error("ready while busy");
  AST_FVEC: assert property (done_o |-> fault_vector_o == (fault_o ? 8'h0d : 8'h00))
    else $error("fault vector");
  AST_NT_HOLD: assert property (done_o && !branch_taken_o |-> $stable(instruction_pointer_o))
    else $error("pointer moved");
  AST_MASK16: assert property (done_o && branch_taken_o && w16_q |->
    instruction_pointer_o[31:16] == 16'h0) else $error("upper half kept");
  AST_WB_ACK: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack");
  AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o) else $error("long ack");

  CVR_CXZ: cover property (done_o && branch_taken_o && cxz_q);
  CVR_FAULT: cover property (done_o && fault_o);
  CVR_NOT: cover property (done_o && !branch_taken_o);
endmodule // cbrres_chk

bind cbrres_top cbrres_chk i_cbrres_chk (.*);
`default_nettype wire

// ===== testbench/cbrres_fe_model.sv
`timescale 1ns/1ps
`default_nettype none
module cbrres_fe_model (
  input  wire logic  clk_i,
  input  wire logic  ready_i,
  input  wire logic  done_i,
  output logic       valid_o,
  output logic [7:0] op_o,
  output logic [7:0] op2_o,
  output logic [31:0] disp_o,
  output logic [1:0] dsz_o,
  output logic       w32_o,
  output logic [31:0] ip_o,
  output logic       cf_o,
  output logic       zf_o
);
  initial
  begin
    {valid_o, op_o, op2_o, disp_o, dsz_o, w32_o, ip_o, cf_o, zf_o} = '0;
  end

  // Holds the offer until accepted, then scrambles opcode and displacement so neither is reused
  task automatic issue(input logic [7:0] o1, o2, input logic [31:0] d,
      input logic [1:0] ds, input logic w, input logic [31:0] ip,
      input logic c, z, output int lat);
    int n;
    begin
      valid_o <= 1'b1;
      {op_o, op2_o, disp_o, dsz_o, w32_o, ip_o, cf_o, zf_o} <= {o1, o2, d, ds, w, ip, c, z};
      n = 0;
      do begin @(posedge clk_i); n++; end while (!ready_i && n < 20);
      valid_o <= 1'b0;
      op_o <= ~o1;
      disp_o <= ~d;
      lat = 0;
      do begin @(posedge clk_i); lat++; end while (!done_i && lat < 20);
    end
  endtask
endmodule // cbrres_fe_model
`default_nettype wire

// ===== testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, a) begin cmp_count++; if ((a) !== (e)) begin mismatches++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, a); end end
module testbench;
  logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
  logic [7:0]  adr = 0;
  logic [31:0] wdat = 0, q, last_ip;
  int          mismatches = 0, cmp_count = 0, ticks = 0, lat;
  wire logic   ready, done, taken, fault, inval, ack, irq, valid, w32, cf, zf;
  wire logic [7:0]  op, op2, fvec;
  wire logic [31:0] disp, ip, ip_o, rdat;
  wire logic [1:0]  dsz;
  // Opcode, second byte, carry, zero, expected outcome
  logic [27:0] tbl [16] = '{28'h77_00_0_0_1, 28'h77_00_0_1_0, 28'h0f_87_1_0_0,
    28'h0f_87_0_0_1, 28'h73_00_0_1_1, 28'h0f_83_1_0_0, 28'h0f_83_0_1_1, 28'h72_00_1_0_1,
    28'h0f_82_0_1_0, 28'h0f_82_1_1_1, 28'h76_00_0_1_1, 28'h0f_86_1_0_1, 28'h76_00_0_0_0,
    28'h74_00_1_1_1, 28'h0f_84_0_0_0, 28'h0f_84_0_1_1};

  always #5 clk_i = ~clk_i;

  cbrres_fe_model i_cbrres_fe_model (.clk_i(clk_i), .ready_i(ready), .done_i(done),
    .valid_o(valid), .op_o(op), .op2_o(op2), .disp_o(disp), .dsz_o(dsz), .w32_o(w32),
    .ip_o(ip), .cf_o(cf), .zf_o(zf));
  cbrres_top i_cbrres_top (.clk_i(clk_i), .rst_i(rst_i), .issue_valid_i(valid),
    .issue_ready_o(ready), .opcode_i(op), .opcode2_i(op2), .displacement_i(disp),
    .disp_size_i(dsz), .operand_width_attribute_i(w32), .instruction_pointer_i(ip),
    .carry_flag_i(cf), .zero_flag_i(zf), .done_o(done), .branch_taken_o(taken),
    .instruction_pointer_o(ip_o), .fault_o(fault), .fault_vector_o(fvec),
    .invalid_o(inval), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .irq_o(irq));

  // Classic single cycle; waits for ack and returns the read data in q
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    begin
      {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
      n = 0;
      do begin @(posedge clk_i); n++; end while (!ack && n < 20);
      q = rdat;
      {cyc, stb, we} <= 3'b000;
      @(posedge clk_i);
    end
  endtask

  // One branch; a branch not taken must leave the old pointer in place
  task automatic br(input logic [7:0] o1, o2, input logic [31:0] d, input logic [1:0] ds,
      input logic w, input logic [31:0] ipv, input logic c, z, input logic [3:0] n,
      input logic t, f, input logic [31:0] tg);
    begin
      i_cbrres_fe_model.issue(o1, o2, d, ds, w, ipv, c, z, lat);
      `CHK("latency", n, 4'(lat))
      `CHK("taken", t, taken)
      `CHK("fault", f, fault)
      last_ip = t ? tg : last_ip;
      `CHK("target", last_ip, ip_o)
    end
  endtask

  task automatic wrap_up;
    begin
      $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
      if (mismatches == 0 && cmp_count > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask

  // Ceiling well above the roughly 150 cycles the sequence needs
  always @(posedge clk_i)
  begin
    ticks++;
    if (ticks > 3000)
    begin
      mismatches++;
      wrap_up();
    end
  end

  initial
  begin
    last_ip = 0;
    repeat (6) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    wb(0, 8'h10, 0); `CHK("limit", 32'hffff_ffff, q)
    wb(0, 8'h00, 0); `CHK("ctrl", 32'h0, q)
    wb(0, 8'hf0, 0); `CHK("unmapped", 32'h0, q)
    foreach (tbl[i])
      br(tbl[i][27:20], tbl[i][19:12], {tbl[i][27:20] == 8'h0f ? 24'hffffff : 24'h0, 8'h80},
        tbl[i][27:20] == 8'h0f ? 2'd2 : 2'd0, 1, 32'h1000, tbl[i][8], tbl[i][4],
        tbl[i][0] ? 4'd3 : 4'd1, tbl[i][0], 0, 32'h0f80);
    wb(0, 8'h08, 0); `CHK("event bits", 2'b11, q[1:0])
    br(8'h74, 0, 32'h8000, 1, 1, 32'h1_2000, 0, 1, 3, 1, 0, 32'ha000);
    br(8'h74, 0, 32'h10_0000, 2, 0, 32'h1234_fff0, 0, 1, 3, 1, 0, 32'hfff0);
    wb(1, 8'h14, 0);
    br(8'he3, 0, 32'h10, 0, 1, 32'h100, 1, 0, 8, 1, 0, 32'h110);
    wb(1, 8'h14, 5);
    br(8'he3, 0, 32'h10, 0, 1, 32'h100, 0, 1, 5, 0, 0, 0);
    br(8'h90, 0, 0, 0, 1, 32'h100, 0, 1, 1, 0, 0, 0);
    `CHK("invalid", 1'b1, inval)
    wb(1, 8'h0c, 4);
    wb(1, 8'h10, 32'h2000);
    wb(1, 8'h00, 1);
    br(8'h74, 0, 32'h1000, 2, 1, 32'h1000, 0, 1, 3, 1, 0, 32'h2000);
    br(8'h74, 0, 32'h1001, 2, 1, 32'h1000, 0, 1, 3, 0, 1, 0);
    `CHK("vector", 8'h0d, fvec)
    wb(0, 8'h08, 0); `CHK("fault bit", 1'b1, q[2])
    `CHK("irq set", 1'b1, irq)
    wb(1, 8'h08, 4);
    @(posedge clk_i);
    `CHK("irq clear", 1'b0, irq)
    wb(1, 8'h0c, 0);
    br(8'h74, 0, 32'h1001, 2, 1, 32'h1000, 0, 1, 3, 0, 1, 0);
    @(posedge clk_i);
    `CHK("irq masked", 1'b0, irq)
    wb(1, 8'h00, 3);
    br(8'h74, 0, 32'h1001, 2, 1, 32'h1000, 0, 1, 3, 1, 0, 32'h2001);
    wb(1, 8'h00, 0);
    br(8'h74, 0, 32'h2002, 2, 1, 32'h1000, 0, 1, 3, 1, 0, 32'h3002);
    wrap_up();
  end
endmodule // testbench
`default_nettype wire
